// [src/ubhsp_regs.vh]
// Host serial port constants: fields, limits, timing.
// Assumes inclusion by bare name from the port's design file only.
`ifndef UBHSP_REGS_VH
`define UBHSP_REGS_VH

// ----------------------------------------------------------------------------
// SPI command byte layout
// ----------------------------------------------------------------------------
`define UBHSP_SPI_WR_BIT      7
`define UBHSP_SPI_ADDR_MSB    4

// ----------------------------------------------------------------------------
// Register space
// ----------------------------------------------------------------------------
`define UBHSP_ADDR_QUEUE      8'h00
`define UBHSP_ADDR_LAST       8'h1F
`define UBHSP_ADDR_RESET      8'h00

// ----------------------------------------------------------------------------
// I2C slave address and timing
// ----------------------------------------------------------------------------
`define UBHSP_ID_DEFAULT      5'h15
`define UBHSP_I2C_FMAX_KHZ    400
`define UBHSP_CLK_KHZ         50000
`define UBHSP_I2C_MIN_PER_CYC (`UBHSP_CLK_KHZ / `UBHSP_I2C_FMAX_KHZ)

// ----------------------------------------------------------------------------
// Transmit queue and strap capture
// ----------------------------------------------------------------------------
`define UBHSP_TXQ_WIDTH       8
`define UBHSP_TXQ_DEPTH       32
`define UBHSP_TXQ_AW          5
`define UBHSP_STRAP_SETTLE    2'h3

`endif

// [src/ubhsp_top.v]
// Host serial port: SPI mode-0 or I2C slave into the register file.
// Assumes same-cycle register reads and pins far slower than CLK.
//
// Behaviour
// RULE_01: Strap selects SPI or I2C.
// RULE_02: SPI mode 0: sample on rise, shift on fall.
// RULE_03: SPI single accesses and bursts after a command byte.
// RULE_04: Address-zero burst stays put; writes push, reads pop.
// RULE_05: Nonzero burst address increments per byte.
// RULE_06: Select high ends the burst, drops address.
// RULE_07: I2C bus clock up to 400 kHz.
// RULE_08: Seven-bit slave address: five fixed bits plus straps.
// RULE_09: Address bit 1 from data-in pin, bit 0 from select pin.
// RULE_10: First byte after START: address plus direction, 1 read.
// RULE_11: SDA change while SCL high is START or STOP; idle high.
// RULE_12: Register address acked only when valid.
// RULE_13: Writes ack address and every data byte until STOP; the code nacks a queue-address byte when the queue is full.
// RULE_14: Read: address write, repeated START, read address.
// RULE_15: Read: ack, eight bits, continue while master acks.
// RULE_16: Master nack then STOP ends transmission.
// RULE_17: Ack holds SDA low through ninth clock; nack leaves high.
// RULE_18: Master ends with STOP or repeated START.
// RULE_19: I2C bytes advance address, except at zero.
`timescale 1ns/10ps
`include "ubhsp_regs.vh"

// ----------------------------------------------------------------------------
// Transmit queue with registered output stage
// ----------------------------------------------------------------------------
module ubhsp_fifo #(
    parameter WIDTH = `UBHSP_TXQ_WIDTH,
    parameter DEPTH = `UBHSP_TXQ_DEPTH,
    parameter AW    = `UBHSP_TXQ_AW
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    localparam [AW:0] FULL_COUNT = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            load;

    assign in_ready = (count != FULL_COUNT);
    assign push     = in_valid & in_ready;
    assign load     = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_data  <= {WIDTH{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (load) begin
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
                rd_ptr    <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !load) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (!push && load) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // ubhsp_fifo

// ----------------------------------------------------------------------------
// Serial port top
// ----------------------------------------------------------------------------
module ubhsp_top #(
    parameter [4:0] ID_HIGH = `UBHSP_ID_DEFAULT  // Arbitrary value
) (
    input  wire       CLK,
    input  wire       SRST,
    input  wire       SEL_SPI,
    input  wire       SCLK,
    input  wire       CHIP_SELECT_ADDR0_PIN,
    input  wire       DATA_IN_ADDR1_PIN,
    output reg        DOUT,
    input  wire       SDA_IN,
    output reg        SDA_OUT,
    output reg        SDA_OE_N,
    output reg  [7:0] REG_ADDR,
    output reg  [7:0] REG_WDATA,
    output reg        REG_WR,
    output reg        REG_RD,
    input  wire [7:0] REG_RDATA,
    output wire [7:0] TXQ_DATA,
    output wire       TXQ_VALID,
    input  wire       TXQ_READY,
    output reg        TXQ_OVERFLOW
);
    // ------------------------------------------------------------------------
    // States and helpers
    // ------------------------------------------------------------------------
    localparam [2:0] I_IDLE = 3'h0;
    localparam [2:0] I_DEV  = 3'h1;
    localparam [2:0] I_REG  = 3'h2;
    localparam [2:0] I_WR   = 3'h3;
    localparam [2:0] I_RD   = 3'h4;

    // Address zero is the queue window, so it never moves
    function [7:0] advance;
        input [7:0] a;
        begin
            advance = (a == `UBHSP_ADDR_QUEUE) ? a : a + 8'h01;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg       scl_s1, scl_s2, scl_d;
    reg       sda_s1, sda_s2, sda_d;
    reg       cs_s1,  cs_s2;
    reg       din_s1, din_s2;
    reg       sel_s1, sel_s2;

    always @(posedge CLK) begin
        scl_s1 <= SCLK;
        scl_s2 <= scl_s1;
        scl_d  <= scl_s2;
        sda_s1 <= SDA_IN;
        sda_s2 <= sda_s1;
        sda_d  <= sda_s2;
        cs_s1  <= CHIP_SELECT_ADDR0_PIN;
        cs_s2  <= cs_s1;
        din_s1 <= DATA_IN_ADDR1_PIN;
        din_s2 <= din_s1;
        sel_s1 <= SEL_SPI;
        sel_s2 <= sel_s1;
    end

    wire scl_rise = scl_s2 & ~scl_d;  // [RULE_07]
    wire scl_fall = ~scl_s2 & scl_d;
    wire i2c_start = scl_s2 & scl_d & sda_d & ~sda_s2;  // [RULE_11]
    wire i2c_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;  // [RULE_11]

    // ------------------------------------------------------------------------
    // Working state
    // ------------------------------------------------------------------------
    reg [1:0] strap_cnt;
    reg       strap_done;
    reg       mode_spi;
    reg [1:0] addr_low;
    reg [3:0] bit_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg [7:0] addr;
    reg       s_first;
    reg       s_write;
    reg [2:0] i_state;
    reg       ack_now;
    reg [7:0] push_data;
    reg       push_valid;
    wire      txq_ready_in;
    wire [7:0] byte_in = {rx_shift[6:0], mode_spi ? din_s2 : sda_s2};

    // ------------------------------------------------------------------------
    // Transmit queue
    // ------------------------------------------------------------------------
    ubhsp_fifo #(
        .WIDTH (`UBHSP_TXQ_WIDTH),
        .DEPTH (`UBHSP_TXQ_DEPTH),
        .AW    (`UBHSP_TXQ_AW)
    ) u_txq (
        .clk       (CLK),
        .srst      (SRST),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (txq_ready_in),
        .out_data  (TXQ_DATA),
        .out_valid (TXQ_VALID),
        .out_ready (TXQ_READY)
    );

    // ------------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------------
    always @(posedge CLK) begin
        if (SRST) begin
            strap_cnt    <= 2'h0;
            strap_done   <= 1'b0;
            mode_spi     <= 1'b0;
            addr_low     <= 2'h0;
            bit_cnt      <= 4'h0;
            rx_shift     <= 8'h00;
            tx_shift     <= 8'h00;
            addr         <= `UBHSP_ADDR_RESET;
            s_first      <= 1'b1;
            s_write      <= 1'b0;
            i_state      <= I_IDLE;
            ack_now      <= 1'b0;
            push_data    <= 8'h00;
            push_valid   <= 1'b0;
            DOUT         <= 1'b0;
            SDA_OUT      <= 1'b0;
            SDA_OE_N     <= 1'b1;
            REG_ADDR     <= `UBHSP_ADDR_RESET;
            REG_WDATA    <= 8'h00;
            REG_WR       <= 1'b0;
            REG_RD       <= 1'b0;
            TXQ_OVERFLOW <= 1'b0;
        end else begin
            REG_WR       <= 1'b0;
            REG_RD       <= 1'b0;
            push_valid   <= 1'b0;
            TXQ_OVERFLOW <= 1'b0;
            if (!strap_done) begin
                // Straps static; latch after sync
                strap_cnt <= strap_cnt + 2'h1;
                if (strap_cnt == `UBHSP_STRAP_SETTLE) begin
                    strap_done <= 1'b1;
                    mode_spi   <= sel_s2;                        // [RULE_01]
                    addr_low   <= {din_s2, cs_s2};               // [RULE_09]
                end
            end else if (mode_spi) begin
                if (cs_s2) begin
                    // Select high ends any burst and forgets the address
                    s_first  <= 1'b1;                            // [RULE_06]
                    s_write  <= 1'b0;
                    bit_cnt  <= 4'h0;
                    tx_shift <= 8'h00;
                    DOUT     <= 1'b0;
                end else begin
                    if (scl_rise) begin
                        rx_shift <= byte_in;                     // [RULE_02]
                        bit_cnt  <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            if (s_first) begin
                                s_first  <= 1'b0;                // [RULE_03]
                                s_write  <= byte_in[`UBHSP_SPI_WR_BIT];
                                addr     <= {3'h0, byte_in[`UBHSP_SPI_ADDR_MSB:0]};
                                REG_ADDR <= {3'h0, byte_in[`UBHSP_SPI_ADDR_MSB:0]};
                                REG_RD   <= ~byte_in[`UBHSP_SPI_WR_BIT];
                            end else if (s_write) begin
                                if (addr == `UBHSP_ADDR_QUEUE) begin
                                    // Link cannot stall; full queue drops
                                    push_valid   <= txq_ready_in;   // [RULE_04]
                                    push_data    <= byte_in;
                                    TXQ_OVERFLOW <= ~txq_ready_in;
                                end else begin
                                    REG_ADDR  <= addr;
                                    REG_WDATA <= byte_in;
                                    REG_WR    <= 1'b1;
                                end
                                addr <= advance(addr);           // [RULE_05]
                            end else begin
                                // Read ahead for the next fall
                                addr     <= advance(addr);       // [RULE_05]
                                REG_ADDR <= advance(addr);       // [RULE_04]
                                REG_RD   <= 1'b1;
                            end
                        end
                    end
                    if (scl_fall) begin
                        DOUT     <= tx_shift[7];                 // [RULE_02]
                        tx_shift <= {tx_shift[6:0], 1'b0};
                    end
                end
            end else begin
                if (i2c_start) begin
                    i_state  <= I_DEV;                           // [RULE_10]
                    bit_cnt  <= 4'h0;
                    SDA_OE_N <= 1'b1;
                end else if (i2c_stop) begin
                    i_state  <= I_IDLE;                          // [RULE_16]
                    bit_cnt  <= 4'h0;
                    SDA_OE_N <= 1'b1;
                end else if (i_state != I_IDLE) begin
                    if (scl_rise) begin
                        if (bit_cnt != 4'h8) begin
                            rx_shift <= byte_in;
                            bit_cnt  <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                ack_now <= 1'b0;
                                case (i_state)
                                    I_DEV: begin
                                        if (byte_in[7:1] == {ID_HIGH, addr_low}) begin
                                            ack_now <= 1'b1;     // [RULE_08]
                                            if (byte_in[0]) begin
                                                i_state  <= I_RD;   // [RULE_14]
                                                REG_ADDR <= addr;
                                                REG_RD   <= 1'b1;
                                            end else begin
                                                i_state <= I_REG;
                                            end
                                        end else begin
                                            i_state <= I_IDLE;
                                        end
                                    end
                                    I_REG: begin
                                        addr <= byte_in;
                                        if (byte_in <= `UBHSP_ADDR_LAST) begin
                                            ack_now <= 1'b1;     // [RULE_12]
                                            i_state <= I_WR;
                                        end else begin
                                            i_state <= I_IDLE;
                                        end
                                    end
                                    I_WR: begin
                                        addr <= advance(addr);   // [RULE_19]
                                        if (addr == `UBHSP_ADDR_QUEUE) begin
                                            // Full queue refuses by nack
                                            ack_now    <= txq_ready_in;
                                            push_valid <= txq_ready_in;
                                            push_data  <= byte_in;
                                        end else begin
                                            ack_now   <= 1'b1;   // [RULE_13]
                                            REG_ADDR  <= addr;
                                            REG_WDATA <= byte_in;
                                            REG_WR    <= 1'b1;
                                        end
                                    end
                                    default: begin
                                        ack_now <= 1'b0;
                                    end
                                endcase
                            end
                        end else begin
                            bit_cnt <= 4'h0;
                            if (i_state == I_RD && !ack_now) begin
                                if (sda_s2) begin
                                    i_state <= I_IDLE;           // [RULE_16]
                                end else begin
                                    addr     <= advance(addr);   // [RULE_19]
                                    REG_ADDR <= advance(addr);   // [RULE_15]
                                    REG_RD   <= 1'b1;
                                end
                            end
                            ack_now <= 1'b0;
                        end
                    end
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            SDA_OE_N <= ~ack_now;                // [RULE_17]
                        end else if (i_state == I_RD) begin
                            SDA_OE_N <= tx_shift[7];             // [RULE_15]
                            tx_shift <= {tx_shift[6:0], 1'b1};
                        end else begin
                            SDA_OE_N <= 1'b1;
                        end
                    end
                end else if (scl_fall) begin
                    SDA_OE_N <= 1'b1;                            // [RULE_11]
                end
            end
            if (REG_RD) begin
                tx_shift <= REG_RDATA;
            end
        end
    end
endmodule // ubhsp_top

// [verification/ubhsp_checker.sv]
// Checks on the host serial port's top ports.
// Assumes link pins move on CLK falls, far slower than CLK.
`timescale 1ns/10ps
module ubhsp_checker (
    input wire       CLK,
    input wire       SRST,
    input wire       SCLK,
    input wire       CHIP_SELECT_ADDR0_PIN,
    input wire       DOUT,
    input wire       SDA_OUT,
    input wire       SDA_OE_N,
    input wire [7:0] REG_ADDR,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire [7:0] TXQ_DATA,
    input wire       TXQ_VALID,
    input wire       TXQ_READY,
    input wire       TXQ_OVERFLOW
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_burst_end;
        $rose(CHIP_SELECT_ADDR0_PIN) ##1 CHIP_SELECT_ADDR0_PIN [*4];
    endsequence
    sequence s_stall;
        TXQ_VALID && !TXQ_READY;
    endsequence
    a_reset_quiet: assert property ($fell(SRST) |-> SDA_OE_N && !DOUT && !REG_WR
        && !REG_RD && !TXQ_VALID && !TXQ_OVERFLOW) else $error("outputs busy after reset");
    a_sda_open_drain: assert property (!SDA_OUT)
        else $error("sda driven high");
    a_sda_scl_low: assert property ($changed(SDA_OE_N) |-> !SCLK && $past(!SCLK))
        else $error("sda moved while scl high");
    a_dout_on_fall: assert property ($changed(DOUT) |-> !SCLK && $past(!SCLK))
        else $error("dout moved outside clock low");
    a_dout_burst_end: assert property (s_burst_end |-> !DOUT)
        else $error("dout active after select high");
    a_wr_one_cycle: assert property (REG_WR |=> !REG_WR)
        else $error("write pulse too long");
    a_rd_one_cycle: assert property (REG_RD |=> !REG_RD)
        else $error("read pulse too long");
    a_wr_not_queue: assert property (REG_WR |-> REG_ADDR != 8'h00)
        else $error("register write to queue address");
    a_addr_in_range: assert property (REG_WR || REG_RD |-> REG_ADDR <= 8'h1F)
        else $error("access beyond register space");
    a_txq_hold: assert property (s_stall |=> TXQ_VALID && $stable(TXQ_DATA))
        else $error("head moved in stall");
    a_ovf_pulse: assert property (TXQ_OVERFLOW |=> !TXQ_OVERFLOW)
        else $error("overflow pulse too long");
endmodule // ubhsp_checker

bind ubhsp_top ubhsp_checker u_chk (
    .CLK(CLK), .SRST(SRST), .SCLK(SCLK), .CHIP_SELECT_ADDR0_PIN(CHIP_SELECT_ADDR0_PIN),
    .DOUT(DOUT), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .TXQ_DATA(TXQ_DATA), .TXQ_VALID(TXQ_VALID),
    .TXQ_READY(TXQ_READY), .TXQ_OVERFLOW(TXQ_OVERFLOW)
);

// [verification/ubhsp_host_model.sv]
// Host model: SPI mode-0 and I2C master.
// Assumes a pulled-up SDA and calls on a CLK fall.
`timescale 1ns/10ps
module ubhsp_host_model (
    input  wire dout,
    input  wire sda,
    output reg  sclk = 1'b0,
    output reg  cs_pin = 1'b1,
    output reg  mosi_pin = 1'b0,
    output reg  sda_low = 1'b0
);
    // ------------------------------------------------------------
    // Link tasks
    // ------------------------------------------------------------
    task straps(input a1, input a0);
        begin
            mosi_pin = a1;
            cs_pin = a0;
            sclk = 1'b1;
        end
    endtask
    task spi_cs(input v);
        begin
            cs_pin = v;
            #160;
        end
    endtask
    // Long last high phase leaves room for the read-ahead
    task spi_byte(input [7:0] b, output [7:0] r);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                mosi_pin = b[i];
                #80 r[i] = dout;
                sclk = 1'b1;
                #80;
                if (i == 0) #160;
                sclk = 1'b0;
            end
        end
    endtask
    // Also a repeated START; waits out the device's ack release first
    task i2c_start;
        begin
            sda_low = 1'b0;
            #80 sclk = 1'b1;
            #40 sda_low = 1'b1;
            #40 sclk = 1'b0;
        end
    endtask
    task i2c_stop;
        begin
            sda_low = 1'b1;
            #80 sclk = 1'b1;
            #40 sda_low = 1'b0;
            #80;
        end
    endtask
    // Nine clocks: a 1 releases SDA, every bit is read back from the wire
    task i2c_x(input [8:0] tx, output [8:0] rx);
        integer i;
        begin
            for (i = 8; i >= 0; i = i - 1) begin
                #40 sda_low = ~tx[i];
                #40 sclk = 1'b1;
                #40 rx[i] = sda;
                #40 sclk = 1'b0;
            end
        end
    endtask
endmodule // ubhsp_host_model

// [verification/tb_uart_bridge_host_serial_port.sv]
// Bench for the host serial port: SPI, then I2C.
// Assumes the host model drives the link; registers live here.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_uart_bridge_host_serial_port;
    localparam [4:0] ID = 5'h15; // Arbitrary value
    reg         clk, srst, sel_spi, txq_ready, rdy_en;
    reg  [7:0]  mem [0:31];
    reg  [7:0]  shd [0:31];
    reg  [7:0]  rx_cnt, b8;
    reg  [7:0]  exp_q [$];
    reg  [7:0]  got_q [$];
    reg  [31:0] seed;
    reg  [6:0]  sadr;
    reg  [8:0]  rx9;
    integer     err_count, samples_checked, ovf, i;
    wire        sclk, cs, mosi, m_low, dout, sda_out, sda_oe_n;
    wire        reg_wr, reg_rd, txq_valid, txq_ovf;
    wire [7:0]  reg_addr, reg_wdata, txq_data;
    wire        sda = !m_low && (sda_oe_n || sda_out);
    // Address zero pops the receive queue
    wire [7:0]  reg_rdata = (reg_addr == 8'h00) ? 8'h40 + rx_cnt : mem[reg_addr[4:0]];
    // ------------------------------------------------------------
    // Design, host and register file
    // ------------------------------------------------------------
    ubhsp_top #(.ID_HIGH(ID)) uut (
        .CLK(clk), .SRST(srst), .SEL_SPI(sel_spi), .SCLK(sclk),
        .CHIP_SELECT_ADDR0_PIN(cs), .DATA_IN_ADDR1_PIN(mosi), .DOUT(dout),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .TXQ_DATA(txq_data), .TXQ_VALID(txq_valid), .TXQ_READY(txq_ready),
        .TXQ_OVERFLOW(txq_ovf));
    ubhsp_host_model host (.dout(dout), .sda(sda), .sclk(sclk), .cs_pin(cs),
        .mosi_pin(mosi), .sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (reg_wr) mem[reg_addr[4:0]] <= reg_wdata;
        if (reg_rd && reg_addr == 8'h00) rx_cnt <= rx_cnt + 8'h01;
        if (txq_valid && txq_ready) got_q.push_back(txq_data);
        if (txq_ovf) ovf = ovf + 1;
    end
    // Random consumer stalls
    always @(negedge clk) txq_ready <= rdy_en && (rnd8() > 8'h50);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [7:0] rnd8;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd8 = seed[7:0];
        end
    endfunction
    function [7:0] nxt(input [7:0] a);
        nxt = (a == 8'h00) ? a : a + 8'h01;
    endfunction
    task do_reset;
        begin
            srst = 1'b1;
            repeat (6) @(negedge clk);
            srst = 1'b0;
            repeat (8) @(negedge clk);
        end
    endtask
    task chk_mem;
        integer k;
        for (k = 1; k < 32; k = k + 1) `CHK(mem[k], shd[k])
    endtask
    task spi_burst(input wr, input [7:0] a0, input integer n);
        integer k;
        reg [7:0] a, b, r, e, base;
        begin
            a = a0;
            base = rx_cnt;
            host.spi_cs(1'b0);
            host.spi_byte({wr, 2'b00, a0[4:0]}, r);
            for (k = 0; k < n; k = k + 1) begin
                b = rnd8();
                host.spi_byte(b, r);
                e = (a == 8'h00) ? 8'h40 + base + k[7:0] : shd[a[4:0]];
                if (wr && a == 8'h00) exp_q.push_back(b);
                else if (wr) shd[a[4:0]] = b;
                else `CHK(r, e)
                a = nxt(a);
            end
            host.spi_cs(1'b1);
        end
    endtask
    task i2c_hdr(input rw, input [6:0] sa);
        begin
            host.i2c_start;
            host.i2c_x({sa, rw, 1'b1}, rx9);
        end
    endtask
    task i2c_txn(input rd, input [7:0] ra, input integer n);
        integer k;
        reg [7:0] a, b;
        begin
            a = ra;
            i2c_hdr(1'b0, sadr);
            `CHK(rx9[0], 1'b0)
            host.i2c_x({ra, 1'b1}, rx9);
            `CHK(!rx9[0], ra <= 8'h1F)
            if (rd) i2c_hdr(1'b1, sadr);
            if (rd) `CHK(rx9[0], 1'b0)
            for (k = 0; k < n; k = k + 1) begin
                b = rnd8();
                host.i2c_x(rd ? {8'hFF, k == n - 1} : {b, 1'b1}, rx9);
                if (rd) `CHK(rx9[8:1], shd[a[4:0]])
                else `CHK(!rx9[0], ra <= 8'h1F)
                if (!rd && ra <= 8'h1F) shd[a[4:0]] = b;
                a = nxt(a);
            end
            host.i2c_stop;
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        sel_spi = 1'b1;
        rdy_en = 1'b1;
        txq_ready = 1'b0;
        seed = 32'hA4A0723D;
        rx_cnt = 8'h00;
        err_count = 0;
        samples_checked = 0;
        ovf = 0;
        for (i = 0; i < 32; i = i + 1) mem[i] = rnd8();
        for (i = 0; i < 32; i = i + 1) shd[i] = mem[i];
        do_reset;
        spi_burst(1'b1, 8'h05, 3);
        spi_burst(1'b0, 8'h05, 3);
        spi_burst(1'b1, 8'h1D, 3);
        spi_burst(1'b0, 8'h1C, 3);
        spi_burst(1'b0, 8'h00, 3);
        chk_mem;
        // Overfill queue, drain under stalls
        rdy_en = 1'b0;
        spi_burst(1'b1, 8'h00, 40);
        rdy_en = 1'b1;
        for (i = 0; i < 4000 && got_q.size() + ovf < 40; i = i + 1) @(negedge clk);
        if (i == 4000) begin
            err_count = err_count + 1;
            complete_run;
        end
        `CHK(got_q.size() >= 32, 1'b1)
        for (i = 0; i < got_q.size(); i = i + 1) `CHK(got_q[i], exp_q[i])
        $display("spi tests done");
        sel_spi = 1'b0;
        b8 = rnd8();
        sadr = {ID, b8[1:0]};
        host.straps(b8[1], b8[0]);
        do_reset;
        i2c_hdr(1'b0, sadr ^ 7'h01);
        `CHK(rx9[0], 1'b1)
        host.i2c_stop;
        i2c_txn(1'b0, 8'h1D, 3);
        i2c_txn(1'b1, 8'h1C, 3);
        i2c_txn(1'b0, 8'h20, 2);
        chk_mem;
        $display("i2c tests done");
        complete_run;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count = err_count + 1;
        complete_run;
    end
endmodule // tb_uart_bridge_host_serial_port
